// *** src/cpe_regs.sv ***
// apb register bank of the card performance enhancement function
//
// The APB register port was chosen for this implementation.
module cpe_regs #(
   parameter logic                  EVENT_SUPPORTED      = 1'b1,
   parameter logic                  CARD_MAINT_SUPPORTED = 1'b1,
   parameter logic                  HOST_MAINT_SUPPORTED = 1'b1,
   parameter logic                  CACHE_SUPPORTED      = 1'b1,
   parameter logic [7:0]            QUEUE_DEPTH_CODE     = 8'h1f,
   parameter int unsigned           FLUSH_TIMEOUT_CYC    = cpe_pkg::FLUSH_LIMIT_CYC
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output      logic [31:0]         prdata,
   output      logic                pready,
   output      logic                pslverr,
   input  wire logic [1:0]          maint_urgency,
   input  wire logic [63:0]         task_error,
   input  wire logic                power_off,
   input  wire logic                maint_break,
   input  wire logic                flush_done,
   output      logic                event_en,
   output      logic                maint_card_en,
   output      logic                maint_host_en,
   output      logic                maint_start,
   output      logic                cache_en,
   output      logic                cache_flush,
   output      logic                queue_en,
   output      logic                queue_mode,
   output      logic                irq
);

   cpe_pkg::cpe_state_t st_reg;
   cpe_pkg::cpe_state_t st_next;

   logic [8:0]                      idx;
   logic                            in_map;
   logic                            acc;
   logic                            wr_go;
   logic                            rd_go;
   logic                            wr_lane;
   logic [7:0]                      wbyte;
   logic [7:0]                      rbyte;
   logic [7:0]                      queue_code;
   logic                            queue_sup;
   logic [63:0]                     err_vis;
   logic [63:0]                     err_byte_sel;
   logic [2:0]                      err_byte;
   logic                            flush_end;
   logic                            flush_timeout;
   logic                            maint_end;
   logic                            new_error;
   logic [cpe_pkg::IRQ_W-1:0]       events;

   localparam int unsigned          FLUSH_CNT_W = cpe_pkg::FLUSH_CNT_W;

   // depth codes above the legal maximum are treated as no queue at all
   assign queue_code = (QUEUE_DEPTH_CODE > cpe_pkg::QUEUE_DEPTH_MAX) ? 8'h00
                                                                     : QUEUE_DEPTH_CODE; // [R5]
   assign queue_sup  = |queue_code;

   // bit 11 lies past the 512-word window; low two bits are ignored
   assign idx     = paddr[10:2];
   assign in_map  = ~paddr[11];
   assign acc     = psel & penable;
   assign wr_go   = acc & st_reg.pready & pwrite;
   assign rd_go   = acc & st_reg.pready & ~pwrite;
   assign wr_lane = wr_go & pstrb[0] & in_map;
   assign wbyte   = pwdata[7:0];
   assign err_byte = 3'(idx - cpe_pkg::IDX_TASK_ERR_LO);

   // per task: reserved codes and ids beyond the queue depth read zero
   for (genvar t = 0; t < cpe_pkg::TASKS; t++) begin : g_task
      logic live;
      assign live = queue_sup & (8'(t) <= queue_code);
      assign err_vis[2*t]   = live & task_error[2*t] & ~task_error[2*t+1]; // [R6]
      assign err_vis[2*t+1] = 1'b0; // [R6]
   end

   assign err_byte_sel = err_vis >> {err_byte, 3'b000};

   // read mux; anything unnamed answers zero
   always_comb begin
      rbyte = 8'h00; // [R15]
      if (in_map) begin
         case (idx)
            cpe_pkg::IDX_REVISION: begin
               rbyte = cpe_pkg::REVISION_VAL; // [R1]
            end
            cpe_pkg::IDX_EVENT_SUP: begin
               rbyte = {7'h00, EVENT_SUPPORTED}; // [R2]
            end
            cpe_pkg::IDX_MAINT_SUP: begin
               rbyte = {6'h00, HOST_MAINT_SUPPORTED, CARD_MAINT_SUPPORTED};
            end
            cpe_pkg::IDX_MAINT_URG: begin
               rbyte = {6'h00, maint_urgency}; // [R3]
            end
            cpe_pkg::IDX_CACHE_SUP: begin
               rbyte = {7'h00, CACHE_SUPPORTED}; // [R4]
            end
            cpe_pkg::IDX_QUEUE_SUP: begin
               rbyte = queue_code; // [R5]
            end
            cpe_pkg::IDX_EVENT_EN: begin
               rbyte = {7'h00, st_reg.event_en}; // [R7]
            end
            cpe_pkg::IDX_MAINT_EN: begin
               rbyte = {6'h00, st_reg.maint_host_en, st_reg.maint_card_en};
            end
            cpe_pkg::IDX_MAINT_START: begin
               rbyte = {7'h00, st_reg.maint_start}; // [R9]
            end
            cpe_pkg::IDX_CACHE_EN: begin
               rbyte = {7'h00, st_reg.cache_en}; // [R10]
            end
            cpe_pkg::IDX_CACHE_FLUSH: begin
               rbyte = {7'h00, st_reg.cache_flush}; // [R12]
            end
            cpe_pkg::IDX_QUEUE_CTRL: begin
               rbyte = {6'h00, st_reg.queue_mode, st_reg.queue_en}; // [R13]
            end
            cpe_pkg::IDX_IRQ_STATUS: begin
               rbyte = {4'h0, st_reg.irq_status};
            end
            cpe_pkg::IDX_IRQ_MASK: begin
               rbyte = {4'h0, st_reg.irq_mask};
            end
            default: begin
               if (idx >= cpe_pkg::IDX_TASK_ERR_LO && idx <= cpe_pkg::IDX_TASK_ERR_HI) begin
                  rbyte = err_byte_sel[7:0]; // [R6]
               end
            end
         endcase
      end
   end

   // card-side completions
   assign flush_timeout = st_reg.flush_cnt == FLUSH_CNT_W'(FLUSH_TIMEOUT_CYC - 1);
   assign flush_end     = st_reg.cache_flush & (flush_done | flush_timeout); // [R12]
   assign maint_end     = st_reg.maint_start & maint_break; // [R9]
   assign new_error     = |(err_vis & ~st_reg.err_prev);

   always_comb begin
      events = '0;
      events[cpe_pkg::IRQ_FLUSH_DONE] = flush_end;
      events[cpe_pkg::IRQ_MAINT_END]  = maint_end;
      events[cpe_pkg::IRQ_TASK_ERR]   = new_error;
      events[cpe_pkg::IRQ_POWER_OFF]  = power_off;
   end

   always_comb begin
      st_next = st_reg;

      // two-cycle access phase: first cycle loads read data, second completes
      if (acc && !st_reg.pready) begin
         st_next.pready = 1'b1;
         st_next.prdata = {24'h000000, rbyte};
      end
      if (acc && st_reg.pready) begin
         st_next.pready = 1'b0;
         st_next.prdata = 32'h00000000;
      end

      // host writes; unsupported features stay at zero
      if (wr_lane) begin
         case (idx)
            cpe_pkg::IDX_EVENT_EN: begin
               st_next.event_en = wbyte[cpe_pkg::BIT_ENABLE] & EVENT_SUPPORTED; // [R7] [R16]
            end
            cpe_pkg::IDX_MAINT_EN: begin
               st_next.maint_card_en = wbyte[cpe_pkg::BIT_ENABLE] & CARD_MAINT_SUPPORTED; // [R16]
               st_next.maint_host_en = wbyte[cpe_pkg::BIT_HOST_MAINT]
                                       & HOST_MAINT_SUPPORTED; // [R16]
            end
            cpe_pkg::IDX_MAINT_START: begin
               // only a card break or a power-off notice clears the start bit; a host zero is ignored
               if (wbyte[cpe_pkg::BIT_ENABLE] && HOST_MAINT_SUPPORTED) begin
                  st_next.maint_start = 1'b1; // [R8] [R16]
               end
            end
            cpe_pkg::IDX_CACHE_EN: begin
               st_next.cache_en = wbyte[cpe_pkg::BIT_ENABLE] & CACHE_SUPPORTED; // [R10] [R16]
            end
            cpe_pkg::IDX_CACHE_FLUSH: begin
               if (wbyte[cpe_pkg::BIT_ENABLE] && CACHE_SUPPORTED && !st_reg.cache_flush) begin
                  st_next.cache_flush = 1'b1; // [R11] [R16]
               end
            end
            cpe_pkg::IDX_QUEUE_CTRL: begin
               st_next.queue_en   = wbyte[cpe_pkg::BIT_ENABLE] & queue_sup; // [R13] [R16]
               st_next.queue_mode = wbyte[cpe_pkg::BIT_QUEUE_MODE] & queue_sup; // [R13]
            end
            cpe_pkg::IDX_IRQ_MASK: begin
               st_next.irq_mask = wbyte[cpe_pkg::IRQ_W-1:0];
            end
            default: begin
               st_next.prdata = st_next.prdata; // [R15]
            end
         endcase
      end

      // flush limit counter runs only while a flush is pending
      if (st_reg.cache_flush && !flush_end) begin
         st_next.flush_cnt = st_reg.flush_cnt + FLUSH_CNT_W'(1);
      end else begin
         st_next.flush_cnt = '0;
      end
      if (flush_end) begin
         st_next.cache_flush = 1'b0; // [R12]
      end
      if (maint_end) begin
         st_next.maint_start = 1'b0; // [R9]
      end

      // power-off wins over any write in the same cycle
      if (power_off) begin
         st_next.event_en      = 1'b0; // [R14]
         st_next.maint_card_en = 1'b0; // [R14]
         st_next.maint_host_en = 1'b0; // [R14]
         st_next.maint_start   = 1'b0; // [R14]
         st_next.cache_en      = 1'b0; // [R14]
         st_next.cache_flush   = 1'b0; // [R14]
         st_next.queue_en      = 1'b0; // [R14]
         st_next.queue_mode    = 1'b0; // [R14]
         st_next.flush_cnt     = '0;
      end

      st_next.err_prev = err_vis;

      // read clears status, but an event in the same cycle survives
      if (rd_go && in_map && idx == cpe_pkg::IDX_IRQ_STATUS) begin
         st_next.irq_status = events;
      end else begin
         st_next.irq_status = st_reg.irq_status | events;
      end
      st_next.irq = |(st_next.irq_status & st_next.irq_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg            <= '0;
         st_reg.irq_mask   <= cpe_pkg::IRQ_MASK_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata        = st_reg.prdata;
   assign pready        = st_reg.pready;
   assign pslverr       = 1'b0;
   assign event_en      = st_reg.event_en;
   assign maint_card_en = st_reg.maint_card_en;
   assign maint_host_en = st_reg.maint_host_en;
   assign maint_start   = st_reg.maint_start;
   assign cache_en      = st_reg.cache_en;
   assign cache_flush   = st_reg.cache_flush;
   assign queue_en      = st_reg.queue_en;
   assign queue_mode    = st_reg.queue_mode;
   assign irq           = st_reg.irq;

endmodule

// *** shared/cpe_pkg.sv ***
// constants and state layout for the performance enhancement register set
// How it works
// [R1] low half support info, high half controls
// [R2] offset 1 bit 0: event signalling supported
// [R3] offset 3 bits 1:0: maintenance urgency level
// [R4] offset 4 bit 0: cache supported
// [R5] offset 6: queue depth code, 00h unsupported
// [R6] offsets 8-15: two error bits per task
// [R7] offset 257 bit 0: event enable, read back
// [R8] offset 259 bit 0 written one starts maintenance
// [R9] card clears start bit on maintenance break
// [R10] offset 260 bit 0: cache enable drives cache
// [R11] offset 261 bit 0 written one starts flush
// [R12] flush ends within one second, bit cleared
// [R13] offset 262: queue enable and queue mode
// [R14] power-off notice disables every enhancement feature
// [R15] reserved bits and offsets read zero, ignore writes
// [R16] unsupported feature keeps its enable at zero
package cpe_pkg;

   // register indices; byte address on the bus is four times the index
   localparam logic [8:0] IDX_REVISION     = 9'h000;
   localparam logic [8:0] IDX_EVENT_SUP    = 9'h001;
   localparam logic [8:0] IDX_MAINT_SUP    = 9'h002;
   localparam logic [8:0] IDX_MAINT_URG    = 9'h003;
   localparam logic [8:0] IDX_CACHE_SUP    = 9'h004;
   localparam logic [8:0] IDX_QUEUE_SUP    = 9'h006;
   localparam logic [8:0] IDX_TASK_ERR_LO  = 9'h008;
   localparam logic [8:0] IDX_TASK_ERR_HI  = 9'h00f;
   localparam logic [8:0] IDX_EVENT_EN     = 9'h101;
   localparam logic [8:0] IDX_MAINT_EN     = 9'h102;
   localparam logic [8:0] IDX_MAINT_START  = 9'h103;
   localparam logic [8:0] IDX_CACHE_EN     = 9'h104;
   localparam logic [8:0] IDX_CACHE_FLUSH  = 9'h105;
   localparam logic [8:0] IDX_QUEUE_CTRL   = 9'h106;
   localparam logic [8:0] IDX_IRQ_STATUS   = 9'h1f0;
   localparam logic [8:0] IDX_IRQ_MASK     = 9'h1f1;

   // field positions
   localparam int unsigned BIT_ENABLE      = 0;
   localparam int unsigned BIT_HOST_MAINT  = 1;
   localparam int unsigned BIT_QUEUE_MODE  = 1;

   // fixed values
   localparam logic [7:0] REVISION_VAL     = 8'h00;
   localparam logic [7:0] QUEUE_DEPTH_MAX  = 8'h1f;
   localparam int unsigned TASKS           = 32;

   // interrupt status bits
   localparam int unsigned IRQ_W           = 4;
   localparam int unsigned IRQ_FLUSH_DONE  = 0;
   localparam int unsigned IRQ_MAINT_END   = 1;
   localparam int unsigned IRQ_TASK_ERR    = 2;
   localparam int unsigned IRQ_POWER_OFF   = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

   // timing
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned FLUSH_LIMIT_S   = 1;
   localparam int unsigned FLUSH_LIMIT_CYC = FLUSH_LIMIT_S * CLK_HZ;
   localparam int unsigned FLUSH_CNT_W     = 26;

   typedef struct packed {
      logic [31:0]            prdata;
      logic                   pready;
      logic                   event_en;
      logic                   maint_card_en;
      logic                   maint_host_en;
      logic                   maint_start;
      logic                   cache_en;
      logic                   cache_flush;
      logic                   queue_en;
      logic                   queue_mode;
      logic [FLUSH_CNT_W-1:0] flush_cnt;
      logic [2*TASKS-1:0]     err_prev;
      logic [IRQ_W-1:0]       irq_status;
      logic [IRQ_W-1:0]       irq_mask;
      logic                   irq;
   } cpe_state_t;

endpackage

// *** tb/cpe_props.sv ***
// assertion checker for the performance enhancement register bank
module cpe_props #(
   parameter int unsigned FLUSH_TIMEOUT_CYC = 20
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic [1:0]  maint_urgency,
   input wire logic        power_off,
   input wire logic        maint_break,
   input wire logic        flush_done,
   input wire logic        event_en,
   input wire logic        maint_card_en,
   input wire logic        maint_host_en,
   input wire logic        maint_start,
   input wire logic        cache_en,
   input wire logic        cache_flush,
   input wire logic        queue_en,
   input wire logic        queue_mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [31:0] flush_age;
   logic        wr_cyc;
   logic        wr_start;
   logic        wr_flush;
   logic        start_req;
   logic        any_en;
   logic [1:0]  qctl;
   assign wr_cyc    = psel && penable && pready && pwrite && pstrb[0];
   assign wr_start  = wr_cyc && paddr == 12'h40c;
   assign wr_flush  = wr_cyc && paddr == 12'h414;
   assign start_req = wr_start && pwdata[0] && !power_off;
   assign qctl      = {queue_mode, queue_en};
   assign any_en    = event_en || maint_card_en || maint_host_en || maint_start || cache_en
                      || cache_flush || queue_en || queue_mode;
   // age of a pending flush, so the FLUSH_TIMEOUT_CYC + 2 cycle bound is a plain compare
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) flush_age <= 32'h0;
      else flush_age <= cache_flush ? flush_age + 32'h1 : 32'h0;
   end
   sequence s_wr(a);
      wr_cyc && paddr == a && !power_off;
   endsequence
   sequence s_rd_urg;
      psel && penable && !pready && !pwrite && paddr == 12'h00c;
   endsequence
   AST_EVENT_WR: assert property (s_wr(12'h404) |=> event_en == $past(pwdata[0]))
      else $error("event enable did not follow the write");
   AST_CACHE_WR: assert property (s_wr(12'h410) |=> cache_en == $past(pwdata[0]))
      else $error("cache enable did not follow the write");
   AST_QUEUE_WR: assert property (s_wr(12'h418) |=> qctl == $past(pwdata[1:0]))
      else $error("queue control did not follow the write");
   AST_START_WR: assert property (start_req && !maint_break |=> maint_start)
      else $error("maintenance start not set by host write");
   AST_BREAK: assert property (maint_break && !wr_start |=> !maint_start)
      else $error("maintenance start not cleared on break");
   AST_FLUSH_DONE: assert property (flush_done && !wr_flush |=> !cache_flush)
      else $error("flush bit not cleared after flush done");
   AST_FLUSH_BOUND: assert property (flush_age <= FLUSH_TIMEOUT_CYC + 2)
      else $error("flush pending beyond its limit");
   AST_POFF: assert property (power_off |=> !any_en)
      else $error("feature left enabled after power-off notice");
   AST_RD_HI: assert property (prdata[31:8] == 24'h0 && (pready || prdata == 32'h0))
      else $error("read data outside its byte or outside the answer cycle");
   AST_URG: assert property (s_rd_urg ##1 pready |-> prdata[1:0] == $past(maint_urgency))
      else $error("urgency read does not match the core level");
endmodule
bind cpe_regs cpe_props #(.FLUSH_TIMEOUT_CYC(FLUSH_TIMEOUT_CYC)) u_cpe_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .maint_urgency(maint_urgency), .power_off(power_off), .maint_break(maint_break),
   .flush_done(flush_done), .event_en(event_en), .maint_card_en(maint_card_en),
   .maint_host_en(maint_host_en), .maint_start(maint_start), .cache_en(cache_en),
   .cache_flush(cache_flush), .queue_en(queue_en), .queue_mode(queue_mode));

// *** tb/cpe_host.sv ***
// host controller model issuing register accesses over apb
module cpe_host (
   input  wire logic        pclk,
   output      logic        psel,
   output      logic        penable,
   output      logic        pwrite,
   output      logic [11:0] paddr,
   output      logic [31:0] pwdata,
   output      logic [3:0]  pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
   end
   // enables and triggers are host writes of bit 0, except the host maintenance enable at bit 1
   task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= 4'h1;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait-state count assumed; only the bench watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      // released data lines do not keep the last value
      pwdata <= ~{24'h0, d};
      @(posedge pclk);
   endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench of the performance enhancement register bank
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0, pwrite, psel, penable, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [1:0]  maint_urgency = 2'h0;
   logic [63:0] task_error = 64'h5041_0010_0104_145a;
   logic        power_off = 1'b0, maint_break = 1'b0, flush_done = 1'b0;
   logic        event_en, maint_card_en, maint_host_en, maint_start;
   logic        cache_en, cache_flush, queue_en, queue_mode;
   logic [5:0]  en_vec;
   assign en_vec = {event_en, maint_card_en, maint_host_en, cache_en, queue_en, queue_mode};
   int          n_mismatch = 0, checks = 0;
   always #10 pclk = ~pclk;
   cpe_regs #(.FLUSH_TIMEOUT_CYC(20)) u_cpe_regs (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .maint_urgency(maint_urgency), .task_error(task_error), .power_off(power_off),
      .maint_break(maint_break), .flush_done(flush_done), .event_en(event_en),
      .maint_card_en(maint_card_en), .maint_host_en(maint_host_en),
      .maint_start(maint_start), .cache_en(cache_en), .cache_flush(cache_flush),
      .queue_en(queue_en), .queue_mode(queue_mode), .irq(irq));
   cpe_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_host.xfer(a, 1'b1, d, q);
   endtask
   task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] q;
      u_host.xfer(a, 1'b0, 8'h0, q);
      chk(nm, {24'h0, q}, {24'h0, exp});
   endtask
   task automatic edges(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic t_readonly;
      logic [7:0] e;
      rc("revision", 12'h000, 8'h00);
      rc("event_sup", 12'h004, 8'h01);
      rc("maint_sup", 12'h008, 8'h03);
      rc("cache_sup", 12'h010, 8'h01);
      rc("queue_depth", 12'h018, 8'h1f);
      rc("reserved", 12'h014, 8'h00);
      rc("unmapped", 12'h800, 8'h00);
      chk("no_error", pslverr, 1'b0);
      for (int u = 0; u < 4; u++) begin
         maint_urgency <= u[1:0];
         edges(1);
         rc("urgency", 12'h00c, {6'h0, u[1:0]});
      end
      for (int k = 0; k < 8; k++) begin
         // reserved codes 10 and 11 read as no error
         for (int i = 0; i < 4; i++) begin
            e[2*i+:2] = (task_error[8*k+2*i+:2] == 2'b01) ? 2'b01 : 2'b00;
         end
         rc("task_err", 12'(32 + 4 * k), e);
      end
   endtask
   task automatic t_enables;
      logic [11:0] ad[4] = '{12'h404, 12'h408, 12'h410, 12'h418};
      logic [7:0]  ex[4] = '{8'h01, 8'h03, 8'h01, 8'h03};
      for (int i = 0; i < 4; i++) begin
         wr(ad[i], 8'hff);
         rc("enable_rb", ad[i], ex[i]);
      end
      chk("enable_ports", en_vec, 6'h3f);
      for (int i = 0; i < 4; i++) wr(ad[i], 8'h00);
      wr(12'h418, 8'h02);
      chk("mode_only", en_vec, 6'h01);
   endtask
   task automatic t_flush;
      int n;
      wr(12'h7c4, 8'h01);
      wr(12'h414, 8'h01);
      n = 0;
      while (cache_flush === 1'b1 && n < 40) begin
         edges(1);
         n++;
      end
      chk("flush_timeout", n >= 15 && n <= 22, 1);
      edges(3);
      chk("irq_flush", irq, 1);
      // task errors already standing when reset lifts count as new errors
      rc("irq_status", 12'h7c0, 8'h05);
      edges(1);
      chk("irq_cleared", irq, 0);
      wr(12'h414, 8'h01);
      wr(12'h414, 8'h00);
      rc("flush_pending", 12'h414, 8'h01);
      flush_done <= 1'b1;
      edges(1);
      flush_done <= 1'b0;
      edges(1);
      chk("flush_end", cache_flush, 0);
      rc("irq_status2", 12'h7c0, 8'h01);
   endtask
   task automatic t_maint;
      wr(12'h40c, 8'h01);
      chk("start_set", maint_start, 1);
      maint_break <= 1'b1;
      edges(1);
      maint_break <= 1'b0;
      edges(1);
      chk("start_break", maint_start, 0);
      chk("irq_masked", irq, 0);
      rc("start_rb", 12'h40c, 8'h00);
      rc("irq_status3", 12'h7c0, 8'h02);
   endtask
   task automatic t_poff;
      wr(12'h404, 8'h01);
      wr(12'h408, 8'h03);
      wr(12'h410, 8'h01);
      wr(12'h418, 8'h03);
      wr(12'h40c, 8'h01);
      wr(12'h414, 8'h01);
      power_off <= 1'b1;
      edges(1);
      power_off <= 1'b0;
      edges(1);
      chk("poff_ports", {en_vec, maint_start, cache_flush}, 8'h00);
      rc("poff_cache", 12'h410, 8'h00);
   endtask
   task automatic final_report;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #200_000;
      n_mismatch++;
      final_report();
   end
   initial begin
      edges(12);
      presetn <= 1'b1;
      edges(1);
      chk("reset_outs", {event_en, maint_start, cache_en, cache_flush, queue_en, irq}, 6'h00);
      t_readonly();
      t_enables();
      t_flush();
      t_maint();
      t_poff();
      final_report();
   end
endmodule
